// ---- logic/uts_map.vh ----
// Summary of operation
// - completed-transfer status kept in four-entry queue; oldest shown in read-only window.
// - each finished buffer use by the engine writes one new status entry unless all four entries are occupied.
// - later completions queue behind the pending entry, never overwrite it.
// - clearing the transfer-complete flag pops the current entry, advancing the queue.
// - flag sets again within six instruction cycles if another entry waits.
// - empty queue after clear leaves flag cleared; window content then meaningless.
// - token for an enabled direction arriving while all four entries are occupied is answered with NAK.
// - window bits 6 to 3 carry the last transfer's endpoint number.
// - window bit 2 is 1 for IN token, 0 for OUT or SETUP.
// - window bit 1 is 1 for odd bank, 0 for even bank.
// - window bits 7 and 0 read zero; window is read-only.
// - sixteen identical endpoint control registers, endpoints 0 to 15.
// - endpoint control bit 4 enables handshake packets for that endpoint.
// - endpoint control bit 3 clear allows SETUP; IN and OUT need their enables.
// - endpoint control bit 2 set permits OUT; clear refuses OUT.
// - endpoint control bit 1 set permits IN; clear refuses IN.
// - STALL issued sets endpoint bit 0 until firmware clears it or engine reset.
`ifndef UTS_MAP_VH
`define UTS_MAP_VH
`define UTS_STAT_OFS 8'h00
`define UTS_CTL_OFS 8'h04
`define UTS_EP_BASE 8'h40
`define UTS_EP_MASK 8'hc3
`define UTS_STAT_EP_LSB 3
`define UTS_STAT_DIR_BIT 2
`define UTS_STAT_ODD_BIT 1
`define UTS_CTL_FLAG_BIT 0
`define UTS_CTL_FULL_BIT 1
`define UTS_CTL_CNT_LSB 2
`define UTS_EPC_HSHK_BIT 4
`define UTS_EPC_SETUP_DIS_BIT 3
`define UTS_EPC_OUT_BIT 2
`define UTS_EPC_IN_BIT 1
`define UTS_EPC_STALL_BIT 0
`define UTS_EPC_W 5
`define UTS_EPC_RST 5'h00
`define UTS_EP_NUM 16
`define UTS_FIFO_AW 2
`define UTS_ENTRY_W 6
`define UTS_KIND_OUT 2'h0
`define UTS_KIND_IN 2'h1
`define UTS_KIND_SETUP 2'h2
`define UTS_RESP_ACK 2'h0
`define UTS_RESP_NAK 2'h1
`define UTS_RESP_IGNORE 2'h2
`define UTS_CLK_NS 5
`define UTS_TCY_NS 20
`define UTS_REARM_TCY 6
`define UTS_REARM_MAX_CYC ((`UTS_REARM_TCY * `UTS_TCY_NS) / `UTS_CLK_NS)
`define UTS_REARM_CYC 2
`endif

// ---- logic/uts_fifo_mem.v ----
`timescale 1ns/1ps
`default_nettype none
module uts_fifo_mem #(
   parameter AW = 2,
   parameter DW = 6
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire wr_en_in,
   input wire [AW-1:0] wr_addr_in,
   input wire [DW-1:0] wr_data_in,
   input wire [AW-1:0] rd_addr_in,
   output wire [DW-1:0] rd_data_out
);
   reg [DW-1:0] mem_q [0:(1<<AW)-1];
   reg [DW-1:0] rd_q;
   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
   end
   // read lags one edge; flag timing is built around that lag
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_q <= {DW{1'b0}};
      end else begin
         rd_q <= mem_q[rd_addr_in];
      end
   end
   assign rd_data_out = rd_q;
endmodule
`default_nettype wire

// ---- logic/uts_top.v ----
`include "uts_map.vh"
`timescale 1ns/1ps
`default_nettype none
module uts_top #(
   parameter FIFO_AW = `UTS_FIFO_AW
) (
   input wire clk_in,
   input wire nrst_in,
   input wire eng_rst_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   output wire [31:0] prdata_out,
   output wire pready_out,
   output wire pslverr_out,
   input wire xfer_done_in,
   input wire [3:0] xfer_ep_in,
   input wire xfer_in_dir_in,
   input wire xfer_odd_in,
   input wire token_valid_in,
   input wire [3:0] token_ep_in,
   input wire [1:0] token_kind_in,
   input wire stall_in,
   input wire [3:0] stall_ep_in,
   output wire resp_valid_out,
   output wire [1:0] resp_code_out,
   output wire resp_hshk_out,
   output wire xfer_flag_out,
   output wire fifo_full_out,
   output wire xfer_lost_out
);
   localparam [FIFO_AW:0] DEPTH = {1'b1, {FIFO_AW{1'b0}}};
   localparam EW = `UTS_ENTRY_W;
   localparam CW = `UTS_EPC_W;

   // reset release through two stages
   reg rst_s1_q;
   reg rst_s2_q;
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire rst_n = rst_s2_q;

   // bus decode
   wire apb_setup = psel_in & ~penable_in;
   wire apb_acc = psel_in & penable_in;
   wire hit_stat = (paddr_in == `UTS_STAT_OFS);
   wire hit_ctl = (paddr_in == `UTS_CTL_OFS);
   wire hit_ep = ((paddr_in & `UTS_EP_MASK) == `UTS_EP_BASE);
   wire [3:0] ep_idx = paddr_in[5:2];
   wire bus_err = ~(hit_stat | hit_ctl | hit_ep) | (hit_stat & pwrite_in);
   wire wr_ok = apb_acc & pwrite_in & ~bus_err;
   wire wr_ctl = wr_ok & hit_ctl;
   wire wr_ep = wr_ok & hit_ep;

   assign pready_out = 1'b1;
   assign pslverr_out = apb_acc & bus_err;

   // status queue state
   reg [FIFO_AW-1:0] wr_ptr_q;
   reg [FIFO_AW-1:0] rd_ptr_q;
   reg [FIFO_AW:0] cnt_q;
   reg flag_q;
   reg lost_q;
   wire fifo_full = (cnt_q == DEPTH);
   wire [EW-1:0] head;
   // the pop is the flag clear: write one to the flag bit while it is set
   wire pop = flag_q & wr_ctl & pwdata_in[`UTS_CTL_FLAG_BIT];
   // a full queue drops the entry; the token path has already NAKed it
   wire push = xfer_done_in & ~fifo_full & ~eng_rst_in;

   uts_fifo_mem #(
      .AW(FIFO_AW),
      .DW(EW)
   ) u_mem (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .wr_en_in(push),
      .wr_addr_in(wr_ptr_q),
      .wr_data_in({xfer_ep_in, xfer_in_dir_in, xfer_odd_in}),
      .rd_addr_in(rd_ptr_q),
      .rd_data_out(head)
   );

   reg [FIFO_AW:0] cnt_d;
   always @* begin
      cnt_d = cnt_q;
      case ({push, pop})
         2'b10: cnt_d = cnt_q + {{FIFO_AW{1'b0}}, 1'b1};
         2'b01: cnt_d = cnt_q - {{FIFO_AW{1'b0}}, 1'b1};
         default: cnt_d = cnt_q;
      endcase
   end

   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= {FIFO_AW{1'b0}};
         rd_ptr_q <= {FIFO_AW{1'b0}};
         cnt_q <= {(FIFO_AW+1){1'b0}};
         flag_q <= 1'b0;
         lost_q <= 1'b0;
      end else if (eng_rst_in) begin
         wr_ptr_q <= {FIFO_AW{1'b0}};
         rd_ptr_q <= {FIFO_AW{1'b0}};
         cnt_q <= {(FIFO_AW+1){1'b0}};
         flag_q <= 1'b0;
         lost_q <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
         end
         cnt_q <= cnt_d;
         // low for one cycle after a clear, then rearmed while entries wait
         flag_q <= (cnt_q != {(FIFO_AW+1){1'b0}}) & ~pop;
         lost_q <= xfer_done_in & fifo_full;
      end
   end

   assign xfer_flag_out = flag_q;
   assign fifo_full_out = fifo_full;
   assign xfer_lost_out = lost_q;

   // endpoint control registers
   wire [`UTS_EP_NUM*CW-1:0] epc_flat;
   genvar i;
   generate
      for (i = 0; i < `UTS_EP_NUM; i = i + 1) begin : g_ep
         // genvar slices are not portable; a sized copy of the index instead
         localparam [3:0] EP_ID = i;
         reg [CW-1:0] epc_q;
         wire sel_w = wr_ep & (ep_idx == EP_ID);
         wire stall_set = stall_in & (stall_ep_in == EP_ID);
         always @(posedge clk_in or negedge rst_n) begin
            if (!rst_n) begin
               epc_q <= `UTS_EPC_RST;
            end else begin
               if (sel_w) begin
                  epc_q[CW-1:1] <= pwdata_in[CW-1:1];
               end
               // set beats clear; software may clear but never set it
               if (stall_set) begin
                  epc_q[`UTS_EPC_STALL_BIT] <= 1'b1;
               end else if (eng_rst_in) begin
                  epc_q[`UTS_EPC_STALL_BIT] <= 1'b0;
               end else if (sel_w & ~pwdata_in[`UTS_EPC_STALL_BIT]) begin
                  epc_q[`UTS_EPC_STALL_BIT] <= 1'b0;
               end
            end
         end
         assign epc_flat[i*CW +: CW] = epc_q;
      end
   endgenerate

   // register read data, captured in the setup cycle
   wire [7:0] stat_word = {1'b0, head[5:2], head[1], head[0], 1'b0};
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      if (hit_stat) begin
         rd_mux = {24'h00_0000, stat_word};
      end else if (hit_ctl) begin
         rd_mux[`UTS_CTL_FLAG_BIT] = flag_q;
         rd_mux[`UTS_CTL_FULL_BIT] = fifo_full;
         rd_mux[`UTS_CTL_CNT_LSB +: FIFO_AW+1] = cnt_q;
      end else if (hit_ep) begin
         rd_mux[CW-1:0] = epc_flat[ep_idx*CW +: CW];
      end
   end
   reg [31:0] prdata_q;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h0000_0000;
      end else if (apb_setup & ~pwrite_in) begin
         prdata_q <= rd_mux;
      end
   end
   assign prdata_out = prdata_q;

   // token answer: disabled direction is ignored, else full queue NAKs
   wire [CW-1:0] tok_epc = epc_flat[token_ep_in*CW +: CW];
   reg tok_allow;
   always @* begin
      case (token_kind_in)
         `UTS_KIND_OUT: tok_allow = tok_epc[`UTS_EPC_OUT_BIT];
         `UTS_KIND_IN: tok_allow = tok_epc[`UTS_EPC_IN_BIT];
         `UTS_KIND_SETUP: tok_allow = ~tok_epc[`UTS_EPC_SETUP_DIS_BIT];
         default: tok_allow = 1'b0;
      endcase
   end
   reg resp_valid_q;
   reg [1:0] resp_code_q;
   reg resp_hshk_q;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid_q <= 1'b0;
         resp_code_q <= `UTS_RESP_ACK;
         resp_hshk_q <= 1'b0;
      end else begin
         resp_valid_q <= token_valid_in;
         if (token_valid_in) begin
            resp_hshk_q <= tok_epc[`UTS_EPC_HSHK_BIT];
            if (~tok_allow) begin
               resp_code_q <= `UTS_RESP_IGNORE;
            end else if (fifo_full) begin
               resp_code_q <= `UTS_RESP_NAK;
            end else begin
               resp_code_q <= `UTS_RESP_ACK;
            end
         end
      end
   end
   assign resp_valid_out = resp_valid_q;
   assign resp_code_out = resp_code_q;
   assign resp_hshk_out = resp_hshk_q;
endmodule
`default_nettype wire

// ---- testbench/uts_checker_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module uts_checker (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic eng_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic pslverr_out,
   input wire logic xfer_done_in,
   input wire logic token_valid_in,
   input wire logic resp_valid_out,
   input wire logic [1:0] resp_code_out,
   input wire logic xfer_flag_out,
   input wire logic fifo_full_out,
   input wire logic xfer_lost_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_push;
      xfer_done_in && !eng_rst_in;
   endsequence
   sequence s_rearm;
      ##[1:24] xfer_flag_out;
   endsequence
   chk_resp_pulse: assert property (token_valid_in |=> resp_valid_out)
      else $error("token got no response");
   chk_full_nak: assert property (token_valid_in && fifo_full_out |=> resp_code_out != 2'h0)
      else $error("token accepted while queue full");
   chk_drop_full: assert property (fifo_full_out ##0 s_push |=> xfer_lost_out)
      else $error("push while full not reported");
   chk_full_holds: assert property (fifo_full_out && !eng_rst_in && !pwrite_in |=> fifo_full_out)
      else $error("full queue lost an entry");
   chk_rearm_bound: assert property ($fell(xfer_flag_out) && $past(fifo_full_out) && !$past(eng_rst_in) |-> s_rearm)
      else $error("flag not raised again in time");
   chk_push_flag: assert property (!xfer_flag_out && !fifo_full_out ##0 s_push |-> ##[1:2] xfer_flag_out)
      else $error("push did not raise flag");
   chk_eng_clear: assert property (eng_rst_in && !xfer_done_in |=> !xfer_flag_out && !fifo_full_out)
      else $error("engine reset left queue state");
   chk_status_ro: assert property (psel_in && penable_in && pwrite_in && paddr_in == 8'h00 |-> pslverr_out)
      else $error("status write not refused");
endmodule
bind uts_top uts_checker chk_u (.clk_in(clk_in), .nrst_in(nrst_in), .eng_rst_in(eng_rst_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pslverr_out(pslverr_out),
   .xfer_done_in(xfer_done_in), .token_valid_in(token_valid_in), .resp_valid_out(resp_valid_out),
   .resp_code_out(resp_code_out), .xfer_flag_out(xfer_flag_out), .fifo_full_out(fifo_full_out),
   .xfer_lost_out(xfer_lost_out));
`default_nettype wire

// ---- testbench/uts_engine_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module uts_engine_model (
   input wire logic clk_in,
   output logic xd_out,
   output logic [3:0] xep_out,
   output logic xdir_out,
   output logic xodd_out,
   output logic tv_out,
   output logic [3:0] tep_out,
   output logic [1:0] tk_out,
   output logic st_out,
   output logic [3:0] sep_out
);
   initial {xd_out, xep_out, xdir_out, xodd_out, tv_out, tep_out, tk_out, st_out, sep_out} = '0;
   // qualifiers turn to junk after each pulse so stale values never pass
   task xfer(input logic [3:0] ep, input logic d, input logic o);
      @(posedge clk_in);
      {xd_out, xep_out, xdir_out, xodd_out} <= {1'b1, ep, d, o};
      @(posedge clk_in);
      {xd_out, xep_out, xdir_out, xodd_out} <= {1'b0, ~ep, ~d, ~o};
   endtask
   task token(input logic [3:0] ep, input logic [1:0] k);
      @(posedge clk_in);
      {tv_out, tep_out, tk_out} <= {1'b1, ep, k};
      @(posedge clk_in);
      {tv_out, tep_out, tk_out} <= {1'b0, ~ep, ~k};
   endtask
   task stall(input logic [3:0] ep);
      @(posedge clk_in);
      {st_out, sep_out} <= {1'b1, ep};
      @(posedge clk_in);
      {st_out, sep_out} <= {1'b0, ~ep};
   endtask
endmodule
`default_nettype wire

// ---- testbench/usb_transfer_status_and_endpoint_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module usb_transfer_status_and_endpoint_ctrl_test;
   logic clk_in = 0, nrst_in = 0, eng_rst_in = 0, psel = 0, penable = 0, pwrite = 0, err_seen;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, rv, hshk, flag, full, lost, xd, xdir, xodd, tv, st;
   logic [1:0] rc, tk;
   logic [3:0] xep, tep, sep;
   logic [4:0] ctl [16];
   logic [31:0] rdq [$];
   logic [2:0] tkq [$];
   logic [7:0] entq [$];
   integer errors = 0, checks_done = 0, seed = 32'h814c, i, k, n, lost_n = 0;
   initial forever #2.5 clk_in = ~clk_in;
   uts_top dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .eng_rst_in(eng_rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .xfer_done_in(xd), .xfer_ep_in(xep), .xfer_in_dir_in(xdir),
      .xfer_odd_in(xodd), .token_valid_in(tv), .token_ep_in(tep), .token_kind_in(tk), .stall_in(st),
      .stall_ep_in(sep), .resp_valid_out(rv), .resp_code_out(rc), .resp_hshk_out(hshk), .xfer_flag_out(flag),
      .fifo_full_out(full), .xfer_lost_out(lost));
   uts_engine_model host_u (.clk_in(clk_in), .xd_out(xd), .xep_out(xep), .xdir_out(xdir), .xodd_out(xodd),
      .tv_out(tv), .tep_out(tep), .tk_out(tk), .st_out(st), .sep_out(sep));
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cmp_rsp(input logic [2:0] got, input logic [2:0] exp);
      cmp({29'h0, got}, {29'h0, exp});
   endtask
   // reads pass their expected word through d
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic chk);
      @(posedge clk_in);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      if (chk) rdq.push_back(d);
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1) @(posedge clk_in);
      err_seen = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   always @(posedge clk_in) if (psel && penable && pready === 1'b1 && !pwrite && rdq.size() > 0) cmp(prdata, rdq.pop_front());
   always @(posedge clk_in) if (rv === 1'b1) cmp_rsp({hshk, rc}, tkq.pop_front());
   always @(posedge clk_in) if (lost === 1'b1) lost_n++;
   task tok(input logic [3:0] ep, input logic [1:0] kd, input logic f);
      tkq.push_back({ctl[ep][4], ((kd == 2'h0 && !ctl[ep][2]) || (kd == 2'h1 && !ctl[ep][1]) ||
         (kd == 2'h2 && ctl[ep][3]) || kd == 2'h3) ? 2'h2 : (f ? 2'h1 : 2'h0)});
      host_u.token(ep, kd);
   endtask
   task pop_chk(input integer left);
      k = 0;
      do begin
         @(negedge clk_in);
         k++;
      end while (flag !== 1'b1 && k < 24);
      apb(0, 8'h04, {27'h0, left[2:0], left == 4, 1'b1}, 1);
      apb(0, 8'h00, {24'h0, entq.pop_front()}, 1);
      apb(1, 8'h04, 32'h1, 0);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      for (i = 0; i < 16; i++) apb(0, 8'h40 + 8'(4 * i), 32'h0, 1);
      for (i = 0; i < 16; i++) begin
         ctl[i] = 5'($random(seed));
         if (i == 0) ctl[i][3] = 1'b0;
         apb(1, 8'h40 + 8'(4 * i), {27'($random(seed)), ctl[i]}, 0);
         ctl[i][0] = 1'b0;
         apb(0, 8'h40 + 8'(4 * i), {27'h0, ctl[i]}, 1);
      end
      for (i = 0; i < 48; i++) tok(4'(i / 3), 2'(i % 3), 1'b0);
      tok(4'h1, 2'h3, 1'b0);
      for (i = 0; i < 5; i++) begin
         n = $random(seed);
         if (i < 4) entq.push_back({1'b0, n[3:0], n[4], n[5], 1'b0});
         host_u.xfer(n[3:0], n[4], n[5]);
      end
      for (i = 0; i < 48; i++) tok(4'(i / 3), 2'(i % 3), 1'b1);
      for (i = 4; i > 0; i--) pop_chk(i);
      host_u.stall(4'h3);
      apb(0, 8'h4c, {27'h0, ctl[3] | 5'h01}, 1);
      apb(1, 8'h4c, {27'h0, ctl[3]}, 0);
      apb(0, 8'h4c, {27'h0, ctl[3]}, 1);
      host_u.xfer(4'h9, 1'b1, 1'b0);
      host_u.xfer(4'h2, 1'b0, 1'b1);
      @(posedge clk_in) eng_rst_in <= 1'b1;
      @(posedge clk_in) eng_rst_in <= 1'b0;
      apb(0, 8'h04, 32'h0, 1);
      apb(0, 8'h08, 32'h0, 0);
      cmp({31'h0, err_seen}, 32'h1);
      apb(1, 8'h00, 32'hff, 0);
      cmp({31'h0, err_seen}, 32'h1);
      cmp(lost_n, 32'h1);
      finish_test;
   end
endmodule
`default_nettype wire
